//--- rtl/multi_channel_temp_result_format.sv
module multi_channel_temp_result_format #(
    parameter int TIMEOUT_CYCLES = temp_result_pkg::TIMEOUT_CYCLES
) (
    input  wire logic                                                          core_clk,
    input  wire logic                                                          nrst,
    input  wire logic                                                          sclIn,
    input  wire logic                                                          sdaIn,
    output logic                                                               sdaOut,
    output logic                                                               sdaOeN,
    input  wire logic [1:0]                                                    addrSel,
    input  wire logic                                                          convValid,
    input  wire logic [temp_result_pkg::CHAN_BITS-1:0]                         convChannel,
    input  wire logic [temp_result_pkg::RESULT_BITS-1:0]                       convCount,
    input  wire logic [temp_result_pkg::WORD_BITS*temp_result_pkg::NUM_CHANNELS-1:0] limitFirst,
    input  wire logic [temp_result_pkg::WORD_BITS*temp_result_pkg::NUM_CHANNELS-1:0] limitSecond,
    output logic                                                               overTempAlert,
    output logic                                                               overTempAlertSecond,
    output logic                                                               writeStrobe,
    output logic      [7:0]                                                    writePointer,
    output logic      [temp_result_pkg::WORD_BITS-1:0]                         writeWord
);
    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

    temp_result_pkg::port_state_e state;

    logic        sclMeta;
    logic        sclSync;
    logic        sclPrev;
    logic        sdaMeta;
    logic        sdaSync;
    logic        sdaPrev;
    logic [1:0]  addrMeta;
    logic [1:0]  addrSync;
    logic        sclRise;
    logic        sclFall;
    logic        startSeen;
    logic        stopSeen;
    logic [6:0]  slaveAddr;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic        drive;
    logic        readDir;
    logic        byteIdx;
    logic [7:0]  pointer;
    logic [7:0]  wrHigh;
    logic [15:0] wordHold;
    logic [15:0] bankWord;
    logic [3:0]  rdChannel;
    logic        overFirst;
    logic        overSecond;
    logic [TW-1:0] stallCnt;
    logic        timedOut;

    // pins and the address strap come from outside the clock domain
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sclMeta  <= 1'b1;
            sclSync  <= 1'b1;
            sclPrev  <= 1'b1;
            sdaMeta  <= 1'b1;
            sdaSync  <= 1'b1;
            sdaPrev  <= 1'b1;
            addrMeta <= 2'h0;
            addrSync <= 2'h0;
        end else begin
            sclMeta  <= sclIn;
            sclSync  <= sclMeta;
            sclPrev  <= sclSync;
            sdaMeta  <= sdaIn;
            sdaSync  <= sdaMeta;
            sdaPrev  <= sdaSync;
            addrMeta <= addrSel;
            addrSync <= addrMeta;
        end
    end

    assign sclRise   = sclSync && !sclPrev;
    assign sclFall   = !sclSync && sclPrev;
    assign startSeen = sclSync && sclPrev && sdaPrev && !sdaSync;
    assign stopSeen  = sclSync && sclPrev && !sdaPrev && sdaSync;
    assign slaveAddr = temp_result_pkg::SLAVE_ADDR_BASE | {5'h00, addrSync}; // [RL6] [RL8]

    // open-drain data: only ever pulls low, enable is active low
    assign sdaOut = 1'b0;
    assign sdaOeN = !drive;

    function automatic logic [3:0] chanOf(input logic [7:0] p);
        chanOf = temp_result_pkg::NO_CHANNEL;
        if ((p >= temp_result_pkg::SINGLE_PTR_FIRST && p <= temp_result_pkg::SINGLE_PTR_LAST) ||
            (p >= temp_result_pkg::BLOCK_PTR_FIRST && p <= temp_result_pkg::BLOCK_PTR_LAST)) begin
            chanOf = p[3:0];
        end
    endfunction

    assign rdChannel = chanOf(pointer);

    result_bank bank (
        .core_clk    (core_clk),
        .nrst        (nrst),
        .convValid   (convValid),
        .convChannel (convChannel),
        .convCount   (convCount),
        .rdChannel   (rdChannel),
        .limitFirst  (limitFirst),
        .limitSecond (limitSecond),
        .rdWord      (bankWord),
        .overFirst   (overFirst),
        .overSecond  (overSecond)
    );

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            overTempAlert       <= 1'b0;
            overTempAlertSecond <= 1'b0;
        end else begin
            overTempAlert       <= overFirst; // [RL7]
            overTempAlertSecond <= overSecond; // [RL7]
        end
    end

    // clock held low mid-transaction counts toward the timeout
    always_ff @(posedge core_clk) begin
        if (!nrst || state == temp_result_pkg::ST_IDLE || sclSync) begin
            stallCnt <= '0;
        end else if (!timedOut) begin
            stallCnt <= stallCnt + TW'(1); // [RL11]
        end
    end

    assign timedOut = stallCnt == TW'(TIMEOUT_CYCLES - 1);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state        <= temp_result_pkg::ST_IDLE;
            bitCnt       <= 4'h0;
            shift        <= 8'h00;
            drive        <= 1'b0;
            readDir      <= 1'b0;
            byteIdx      <= 1'b0;
            pointer      <= temp_result_pkg::POINTER_RESET;
            wrHigh       <= 8'h00;
            wordHold     <= temp_result_pkg::RESULT_RESET;
            writeStrobe  <= 1'b0;
            writePointer <= temp_result_pkg::POINTER_RESET;
            writeWord    <= temp_result_pkg::RESULT_RESET;
        end else begin
            writeStrobe <= 1'b0;
            if (timedOut || stopSeen) begin
                state <= temp_result_pkg::ST_IDLE; // [RL11]
                drive <= 1'b0;
            end else if (startSeen) begin
                state  <= temp_result_pkg::ST_ADDR;
                bitCnt <= 4'h0;
                drive  <= 1'b0;
            end else begin
                unique case (state)
                    temp_result_pkg::ST_IDLE: begin
                    end
                    temp_result_pkg::ST_ADDR, temp_result_pkg::ST_PTR, temp_result_pkg::ST_WDATA: begin
                        if (sclRise && bitCnt < temp_result_pkg::BYTE_BITS) begin
                            shift  <= {shift[6:0], sdaSync}; // [RL10]
                            bitCnt <= bitCnt + 4'h1;
                        end else if (sclFall && bitCnt == temp_result_pkg::BYTE_BITS) begin
                            bitCnt <= 4'h0;
                            if (state == temp_result_pkg::ST_ADDR) begin
                                if (shift[7:1] == slaveAddr) begin // [RL8]
                                    readDir <= shift[0];
                                    drive   <= 1'b1;
                                    state   <= temp_result_pkg::ST_ADDR_ACK;
                                end else begin
                                    state <= temp_result_pkg::ST_IDLE;
                                end
                            end else if (state == temp_result_pkg::ST_PTR) begin
                                pointer <= shift;
                                drive   <= 1'b1;
                                state   <= temp_result_pkg::ST_PTR_ACK;
                            end else begin
                                drive <= 1'b1;
                                state <= temp_result_pkg::ST_WACK;
                                if (byteIdx) begin
                                    writeStrobe  <= 1'b1; // [RL9]
                                    writeWord    <= {wrHigh, shift};
                                    writePointer <= pointer;
                                end else begin
                                    wrHigh <= shift;
                                end
                            end
                        end
                    end
                    temp_result_pkg::ST_ADDR_ACK: begin
                        if (sclFall) begin
                            if (readDir) begin
                                // latch the whole word so both bytes come from one conversion
                                wordHold <= bankWord;
                                drive    <= !bankWord[15]; // [RL4] [RL10]
                                shift    <= {bankWord[14:8], 1'b0};
                                bitCnt   <= 4'h1;
                                byteIdx  <= 1'b0;
                                state    <= temp_result_pkg::ST_RD;
                            end else begin
                                drive   <= 1'b0;
                                bitCnt  <= 4'h0;
                                state   <= temp_result_pkg::ST_PTR;
                            end
                        end
                    end
                    temp_result_pkg::ST_PTR_ACK, temp_result_pkg::ST_WACK: begin
                        if (sclFall) begin
                            drive   <= 1'b0;
                            byteIdx <= (state == temp_result_pkg::ST_WACK) ? !byteIdx : 1'b0; // [RL9]
                            state   <= temp_result_pkg::ST_WDATA;
                        end
                    end
                    temp_result_pkg::ST_RD: begin
                        if (sclFall) begin
                            if (bitCnt < temp_result_pkg::BYTE_BITS) begin
                                drive  <= !shift[7]; // [RL10]
                                shift  <= {shift[6:0], 1'b0};
                                bitCnt <= bitCnt + 4'h1;
                            end else begin
                                drive  <= 1'b0;
                                bitCnt <= 4'h0;
                                state  <= temp_result_pkg::ST_RACK;
                            end
                        end
                    end
                    temp_result_pkg::ST_RACK: begin
                        if (sclRise && sdaSync) begin
                            state <= temp_result_pkg::ST_IDLE;
                        end else if (sclFall) begin
                            bitCnt <= 4'h1;
                            state  <= temp_result_pkg::ST_RD;
                            if (!byteIdx) begin
                                drive   <= !wordHold[7]; // [RL4]
                                shift   <= {wordHold[6:0], 1'b0};
                                byteIdx <= 1'b1;
                                // pointers at or above the mirror range start walk through channels; at or past its end they wrap to its start
                                if (pointer >= temp_result_pkg::BLOCK_PTR_FIRST) begin
                                    pointer <= (pointer >= temp_result_pkg::BLOCK_PTR_LAST) ?
                                               temp_result_pkg::BLOCK_PTR_FIRST : pointer + 8'h01;
                                end
                            end else begin
                                wordHold <= bankWord;
                                drive    <= !bankWord[15];
                                shift    <= {bankWord[14:8], 1'b0};
                                byteIdx  <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        state <= temp_result_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_addr_match: assert property ($rose(state == temp_result_pkg::ST_ADDR_ACK) |-> // [RL6]
                                   $past(shift[7:1]) == {5'h12, addrSync})
        else $error("acknowledged a foreign slave address");
    a_high_byte: assert property (state == temp_result_pkg::ST_ADDR_ACK && sclFall && readDir |=> // [RL4]
                                  drive == !wordHold[15] && shift[7:1] == wordHold[14:8])
        else $error("high byte not sent first");
    a_msb_first: assert property (state == temp_result_pkg::ST_RD && sclFall && bitCnt < 4'h8 |=> // [RL10]
                                  drive == !$past(shift[7]))
        else $error("transmit order is not msb first");
    a_write_commit: assert property (writeStrobe |-> $past(state) == temp_result_pkg::ST_WDATA && // [RL9]
                                     $past(byteIdx) && state == temp_result_pkg::ST_WACK && drive)
        else $error("write committed outside the second byte acknowledge");
    a_no_early: assert property (state == temp_result_pkg::ST_WDATA && !byteIdx |=> !writeStrobe) // [RL9]
        else $error("write committed after first byte");
    a_alert_follow: assert property (overFirst ##1 overFirst |-> overTempAlert) // [RL7]
        else $error("first alert does not follow its comparison");
    a_alert_second: assert property (!overSecond |=> !overTempAlertSecond) // [RL7]
        else $error("second alert set without a comparison over limit");
    a_timeout_idle: assert property (timedOut && !startSeen |=> state == temp_result_pkg::ST_IDLE && !drive) // [RL11]
        else $error("stalled transaction did not return to idle");

    c_word_write: cover property (writeStrobe);
    c_block_read: cover property (state == temp_result_pkg::ST_RACK && pointer == 8'h81);
    c_timeout:    cover property (timedOut);
endmodule

//--- rtl/temp_result_pkg.sv
// How it works
// [RL1] results are 13-bit counts of 0.0625 C, left-justified, low three bits zero
// [RL2] negative temperatures are two's complement in the same 16-bit word
// [RL3] word spans -256 C up to +255.9375 C
// [RL4] two bytes per result, high byte LSB weighs 2 C, low byte 1 C down to 0.0625 C
// [RL5] one local and eight remote channels, each with its own word
// [RL6] slave address picks one of four by the address-select pin
// [RL7] two over-temperature alerts follow limit comparisons of the results
// [RL8] addresses 1001000..1001011 for ground, supply, data line, clock line
// [RL9] writes carry two bytes; word committed at acknowledge of second byte
// [RL10] every byte goes most significant bit first, both directions
// [RL11] a stalled transaction past the bus timeout returns the port to idle
package temp_result_pkg;
    localparam int RESULT_BITS  = 13;
    localparam int PAD_BITS     = 3;
    localparam int WORD_BITS    = 16;
    localparam int NUM_CHANNELS = 9;
    localparam int CHAN_BITS    = 4;

    localparam logic [6:0] SLAVE_ADDR_BASE  = 7'h48;
    localparam logic [7:0] SINGLE_PTR_FIRST = 8'h00;
    localparam logic [7:0] SINGLE_PTR_LAST  = 8'h08;
    localparam logic [7:0] BLOCK_PTR_FIRST  = 8'h80;
    localparam logic [7:0] BLOCK_PTR_LAST   = 8'h88;
    localparam logic [3:0] BYTE_BITS        = 4'h8;
    localparam logic [3:0] NO_CHANNEL       = 4'hf;

    localparam logic [15:0] RESULT_RESET  = 16'h0000;
    localparam logic [7:0]  POINTER_RESET = 8'h00;

    localparam int CORE_CLK_HZ    = 40_000_000;
    localparam int TIMEOUT_MS     = 15;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CORE_CLK_HZ / 1000);

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_ADDR     = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_PTR      = 4'h3,
        ST_PTR_ACK  = 4'h4,
        ST_WDATA    = 4'h5,
        ST_WACK     = 4'h6,
        ST_RD       = 4'h7,
        ST_RACK     = 4'h8
    } port_state_e;
endpackage

//--- rtl/result_bank.sv
module result_bank (
    input  wire logic                                                          core_clk,
    input  wire logic                                                          nrst,
    input  wire logic                                                          convValid,
    input  wire logic [temp_result_pkg::CHAN_BITS-1:0]                         convChannel,
    input  wire logic [temp_result_pkg::RESULT_BITS-1:0]                       convCount,
    input  wire logic [temp_result_pkg::CHAN_BITS-1:0]                         rdChannel,
    input  wire logic [temp_result_pkg::WORD_BITS*temp_result_pkg::NUM_CHANNELS-1:0] limitFirst,
    input  wire logic [temp_result_pkg::WORD_BITS*temp_result_pkg::NUM_CHANNELS-1:0] limitSecond,
    output logic      [temp_result_pkg::WORD_BITS-1:0]                         rdWord,
    output logic                                                               overFirst,
    output logic                                                               overSecond
);
    localparam int W = temp_result_pkg::WORD_BITS;
    localparam int N = temp_result_pkg::NUM_CHANNELS;

    logic [W-1:0] words [N];

    // count sits left-justified; sign travels with the count
    function automatic logic [W-1:0] toWord(input logic [temp_result_pkg::RESULT_BITS-1:0] c);
        toWord = {c, {temp_result_pkg::PAD_BITS{1'b0}}}; // [RL1] [RL2] [RL3]
    endfunction

    always_ff @(posedge core_clk) begin
        for (int i = 0; i < N; i++) begin
            if (!nrst) begin
                words[i] <= temp_result_pkg::RESULT_RESET;
            end else if (convValid && convChannel == 4'(i)) begin
                words[i] <= toWord(convCount); // [RL5]
            end
        end
    end

    always_comb begin
        rdWord = temp_result_pkg::RESULT_RESET;
        if (rdChannel < 4'(N)) begin
            rdWord = words[rdChannel];
        end
    end

    always_comb begin
        overFirst  = 1'b0;
        overSecond = 1'b0;
        for (int i = 0; i < N; i++) begin
            if ($signed(words[i]) > $signed(limitFirst[i*W +: W])) begin
                overFirst = 1'b1; // [RL7]
            end
            if ($signed(words[i]) > $signed(limitSecond[i*W +: W])) begin
                overSecond = 1'b1; // [RL7]
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_word_format: assert property (convValid && convChannel == 4'h0 |=> words[0] == {$past(convCount), 3'h0}) // [RL1]
        else $error("stored word is not the left-justified count");
    a_sign_kept: assert property (convValid && convChannel == 4'h3 && convCount[12] |=> words[3][15]) // [RL2]
        else $error("negative count lost its sign");
    a_chan_isolate: assert property (convValid && convChannel != 4'h8 |=> $stable(words[8])) // [RL5]
        else $error("write to one channel disturbed another");
endmodule

//--- sim/two_wire_master.sv
module two_wire_master #(
    parameter int HALF = 8
) (
    input  wire logic core_clk,
    input  wire logic sdaLine,
    output logic      sclOut,
    output logic      sdaPull
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        sclOut = 1'b1;
        sdaPull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // also serves as repeated start: data is released before the clock rises
    task automatic start();
        sdaPull <= 1'b0;
        tick(HALF);
        sclOut <= 1'b1;
        tick(HALF);
        sdaPull <= 1'b1;
        tick(HALF);
        sclOut <= 1'b0;
        tick(2);
    endtask

    task automatic stop();
        sdaPull <= 1'b1;
        tick(HALF);
        sclOut <= 1'b1;
        tick(HALF);
        sdaPull <= 1'b0;
        tick(HALF);
    endtask

    // data moves two cycles after the clock falls, never while it is high
    task automatic bitCycle(input logic b, output logic got);
        sdaPull <= ~b;
        tick(HALF);
        sclOut <= 1'b1;
        tick(HALF / 2);
        got = sdaLine;
        tick(HALF / 2);
        sclOut <= 1'b0;
        tick(2);
    endtask

    task automatic sendByte(input logic [7:0] v, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) bitCycle(v[i], g);
        bitCycle(1'b1, g);
        ack = ~g;
    endtask

    task automatic recvByte(input logic last, output logic [7:0] v);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bitCycle(1'b1, g);
            v[i] = g;
        end
        bitCycle(last, g);
    endtask
endmodule

//--- sim/multi_channel_temp_result_format_tb_top.sv
module multi_channel_temp_result_format_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LW = temp_result_pkg::WORD_BITS * temp_result_pkg::NUM_CHANNELS;
    logic          core_clk = 1'b0;
    logic          nrst;
    logic          sclOut, sdaPull, sdaWire, sdaOut, sdaOeN;
    logic [1:0]    addrSel;
    logic          convValid;
    logic [3:0]    convChannel;
    logic [12:0]   convCount;
    logic [LW-1:0] limitFirst;
    logic [LW-1:0] limitSecond;
    logic          overTempAlert, overTempAlertSecond, writeStrobe;
    logic [7:0]    writePointer;
    logic [15:0]   writeWord;
    logic [15:0]   stored [9];
    logic [15:0]   lfsr = 16'h0035;
    int            n_mismatch = 0;
    int            tests_run = 0;
    int            nStrobe = 0;

    always #12.5 core_clk = ~core_clk;
    // pulled-up wire: low if either party pulls
    assign sdaWire = !(sdaPull || (!sdaOeN && !sdaOut));

    multi_channel_temp_result_format #(.TIMEOUT_CYCLES(200)) dut (
        .core_clk(core_clk), .nrst(nrst), .sclIn(sclOut), .sdaIn(sdaWire), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .addrSel(addrSel), .convValid(convValid), .convChannel(convChannel),
        .convCount(convCount), .limitFirst(limitFirst), .limitSecond(limitSecond),
        .overTempAlert(overTempAlert), .overTempAlertSecond(overTempAlertSecond),
        .writeStrobe(writeStrobe), .writePointer(writePointer), .writeWord(writeWord)
    );
    two_wire_master #(.HALF(8)) master (
        .core_clk(core_clk), .sdaLine(sdaWire), .sclOut(sclOut), .sdaPull(sdaPull)
    );

    always @(posedge core_clk) if (writeStrobe === 1'b1) nStrobe <= nStrobe + 1;

    function automatic logic [15:0] nextRand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // strict signed greater-than, no hysteresis
    function automatic logic expAlert(input logic [LW-1:0] lim);
        logic r = 1'b0;
        for (int i = 0; i < 9; i++) if ($signed(stored[i]) > $signed(lim[16*i +: 16])) r = 1'b1;
        return r;
    endfunction

    task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic store(input logic [3:0] ch, input logic [12:0] cnt);
        convValid <= 1'b1;
        convChannel <= ch;
        convCount <= cnt;
        @(posedge core_clk);
        convValid <= 1'b0;
        @(posedge core_clk);
        if (ch < 4'h9) stored[ch] = {cnt, 3'h0};
    endtask

    // opens a read at ptr; caller takes the bytes and stops
    task automatic openRead(input logic [7:0] ptr);
        logic a;
        master.start();
        master.sendByte({5'h12, addrSel, 1'b0}, a);
        master.sendByte(ptr, a);
        master.start();
        master.sendByte({5'h12, addrSel, 1'b1}, a);
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        logic [15:0]   w, w2;
        logic          a;
        logic [LW-1:0] l1, l2;
        int            n0;
        nrst <= 1'b0;
        addrSel <= 2'h0;
        convValid <= 1'b0;
        convChannel <= 4'h0;
        convCount <= 13'h0000;
        limitFirst <= '0;
        limitSecond <= '0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        master.tick(4);
        for (int s = 0; s < 4; s++) begin
            addrSel <= 2'(s);
            master.tick(4);
            master.start();
            master.sendByte({5'h12, 2'(s), 1'b0}, a);
            checkBit(a, 1'b1);
            master.stop();
            master.start();
            master.sendByte({5'h12, 2'(s) ^ 2'h1, 1'b0}, a);
            checkBit(a, 1'b0);
            master.stop();
        end
        $display("test address done");
        store(4'h0, 13'h1fff);
        store(4'h1, 13'h1000);
        store(4'h2, 13'h0fff);
        for (int i = 3; i < 9; i++) begin
            lfsr = nextRand(lfsr);
            store(4'(i), lfsr[12:0]);
        end
        store(4'hc, 13'h0aaa);
        for (int i = 0; i < 9; i++) begin
            openRead(8'(i));
            master.recvByte(1'b0, w[15:8]);
            master.recvByte(1'b1, w[7:0]);
            master.stop();
            checkWord(w, stored[i]);
        end
        openRead(8'h87);
        for (int i = 0; i < 3; i++) begin
            master.recvByte(1'b0, w[15:8]);
            master.recvByte(i == 2, w[7:0]);
            checkWord(w, stored[(i + 7) % 9]);
        end
        master.stop();
        $display("test readback done");
        for (int k = 0; k < 6; k++) begin
            for (int i = 0; i < 9; i++) begin
                lfsr = nextRand(lfsr);
                l1[16*i +: 16] = (k == 0 || lfsr[1]) ? stored[i] : stored[i] + (lfsr[0] ? 16'h0008 : 16'hfff8);
                l2[16*i +: 16] = (k == 0 || lfsr[3]) ? stored[i] : stored[i] + (lfsr[2] ? 16'h0008 : 16'hfff8);
            end
            limitFirst <= l1;
            limitSecond <= l2;
            master.tick(3);
            checkBit(overTempAlert, expAlert(l1));
            checkBit(overTempAlertSecond, expAlert(l2));
        end
        $display("test alerts done");
        lfsr = nextRand(lfsr);
        w = lfsr;
        w2 = nextRand(lfsr);
        n0 = nStrobe;
        master.start();
        master.sendByte({5'h12, addrSel, 1'b0}, a);
        master.sendByte(8'h05, a);
        master.sendByte(w[15:8], a);
        master.sendByte(w[7:0], a);
        master.sendByte(w2[15:8], a);
        master.sendByte(w2[7:0], a);
        master.sendByte(8'h3c, a);
        master.stop();
        checkWord(16'(nStrobe - n0), 16'h0002);
        checkWord(writeWord, w2);
        checkWord({8'h00, writePointer}, 16'h0005);
        $display("test write done");
        store(4'h2, 13'h0190);
        openRead(8'h02);
        master.tick(10);
        checkBit(sdaOeN, 1'b0);
        master.tick(230);
        checkBit(sdaOeN, 1'b1);
        master.stop();
        openRead(8'h02);
        master.recvByte(1'b0, w[15:8]);
        master.recvByte(1'b1, w[7:0]);
        master.stop();
        checkWord(w, 16'h0c80);
        $display("test timeout done");
        final_report();
    end
endmodule
